// ---- design/io_support_regs_defs.vh ----
// How it works
// - support register read/write; upper half steers internal logic and the SCSI direction pin, lower half except bits 15 and 12 drives pins
// - support bits 31..28 enable port1 tx, port1 rx, port2 tx, port2 rx DMA
// - support bit 18 sets SCSI DMA direction, 0 reads memory, resets 0
// - support bit 17 enables SCSI DMA
// - support bit 16 enables Ethernet DMA
// - support bit 15 reads the manufacturing diagnostic pin level
// - support bits 14:13 disable serial drivers, bit 13 port1, reset 0
// - support bit 11 low holds serial controllers in reset, resets 0
// - support bit 10 low holds time-of-year clock in reset, resets 0
// - support bit 9 low holds SCSI controller in reset, resets 0
// - support bit 8 low holds Ethernet controller in reset, resets 0
// - status bits 31:24 and 19:16 set by DMA hardware, bits 23:20 read 0; write 0 clears, write 1 keeps
// - status bits 31:16 clear at reset
// - status bits 15:0 read-only; bits 14:4 and 2:0 follow live device levels, bits 15 and 3 read 0
// - lower status bit map of jumpers, slots, controllers, power warning, halt contacts
// - upper status bit map of port, SCSI and Ethernet DMA conditions
// - port1 tx DMA runs to a 4-Kbyte boundary, stops, sets bit 31
// - port1 tx DMA stays stopped while bit 31 set; clearing restarts it
// - port1 tx error sets bit 30, stops DMA, pointer keeps failing address
// - processor interrupt only for status bits with mask 1; mask resets 0
// - port1 rx page boundary sets bits 28 and 29, stops DMA
`ifndef IO_SUPPORT_REGS_DEFS_VH
`define IO_SUPPORT_REGS_DEFS_VH

// register addresses
`define SUPPORT_CTRL_ADDR   32'hBF840100
`define INTR_STATUS_ADDR    32'hBF840110
`define INTR_MASK_ADDR      32'hBF840120

// support register fields
`define SUP_P1_TX_EN_BIT    31
`define SUP_SCSI_DIR_BIT    18
`define SUP_SCSI_EN_BIT     17
`define SUP_ENET_EN_BIT     16
`define SUP_DIAG_BIT        15
`define SUP_DRV_DIS_LO      13
`define SUP_DRV_DIS_HI      14
`define SUP_SER_RST_BIT     11
`define SUP_TOY_RST_BIT     10
`define SUP_SCSI_RST_BIT    9
`define SUP_ENET_RST_BIT    8
`define SUP_LED_LO          0
`define SUP_LED_HI          7
`define SUP_WRITE_MASK      32'hF0076FFF
`define SUP_RESET           32'h00000000

// status register fields
`define ST_P1_BASE          31
`define ST_P2_BASE          27
`define ST_SCSI_PTR_BIT     19
`define ST_SCSI_OVR_BIT     18
`define ST_SCSI_RERR_BIT    17
`define ST_ENET_RERR_BIT    16
`define ST_UPPER_MASK       16'hFF0F
`define ST_UPPER_RESET      16'h0000
`define ST_LOWER_RESET      16'h0000
`define MASK_RESET          32'h00000000

// page geometry of the serial DMA pointers
`define PAGE_LAST           12'hFFF
`define HALF_PAGE_LAST      11'h7FF

`endif

// ---- design/dma_page_channel.v ----
`timescale 1ns/100ps
`include "io_support_regs_defs.vh"

module dma_page_channel (
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    // control
    input  wire        run_i,
    input  wire        load_i,
    input  wire [31:0] load_ptr_i,
    // transfer progress
    input  wire        xfer_i,
    input  wire        err_i,
    // results
    output wire [31:0] ptr_o,
    output wire        page_end_o,
    output wire        half_page_o,
    output wire        error_o
);

    reg  [31:0] ptr_r;
    reg  [31:0] ptr_nxt;
    wire        step;

    // an error cycle does not advance, so the pointer names the failing word
    assign step        = run_i & xfer_i & ~err_i;
    assign error_o     = run_i & err_i;
    assign page_end_o  = step & (ptr_r[11:0] == `PAGE_LAST);
    assign half_page_o = step & (ptr_r[10:0] == `HALF_PAGE_LAST);
    assign ptr_o       = ptr_r;

    always @* begin
        ptr_nxt = ptr_r;
        if (load_i) begin
            ptr_nxt = load_ptr_i;
        end else if (step) begin
            ptr_nxt = ptr_r + 32'h00000001;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_r <= 32'h00000000;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

endmodule // dma_page_channel

// ---- design/io_support_regs.v ----
`timescale 1ns/100ps
`include "io_support_regs_defs.vh"

module io_support_regs (
    // clock and reset
    input  wire         clk_sys_i,
    input  wire         resetn_i,
    // register access from the processor
    input  wire         reg_req_i,
    input  wire         reg_wr_i,
    input  wire [31:0]  reg_addr_i,
    input  wire [31:0]  reg_wdata_i,
    output wire [31:0]  reg_rdata_o,
    output wire         reg_ack_o,
    // live device status
    input  wire         manufacturing_diag_flag_i,
    input  wire         nvr_reset_jumper_i,
    input  wire [2:0]   slot_irq_i,
    input  wire         manufacturing_mode_jumper_i,
    input  wire         scsi_irq_i,
    input  wire         enet_irq_i,
    input  wire [1:0]   serial_comm_controller_irq_i,
    input  wire         time_of_year_clock_irq_i,
    input  wire         power_supply_warning_i,
    input  wire         scsi_data_ready_i,
    input  wire         halt_button_closed_contact_i,
    input  wire         halt_button_open_contact_i,
    // serial DMA channels: 0 p1 tx, 1 p1 rx, 2 p2 tx, 3 p2 rx
    input  wire [3:0]   chan_xfer_i,
    input  wire [1:0]   chan_err_i,
    input  wire [3:0]   chan_load_i,
    input  wire [127:0] chan_load_ptr_i,
    output wire [3:0]   chan_run_o,
    output wire [127:0] chan_ptr_o,
    // SCSI and Ethernet DMA conditions
    input  wire         scsi_ptr_loaded_i,
    input  wire         scsi_overrun_i,
    input  wire         scsi_read_err_i,
    input  wire         enet_read_err_i,
    output wire         scsi_dma_run_o,
    output wire         scsi_dma_dir_o,
    output wire         enet_dma_run_o,
    // peripheral control pins
    output wire [1:0]   serial_driver_disable_o,
    output wire         serial_comm_controller_reset_n_o,
    output wire         time_of_year_clock_reset_n_o,
    output wire         scsi_reset_n_o,
    output wire         enet_reset_n_o,
    output wire [7:0]   led_o,
    // processor interrupt
    output wire         cpu_irq_o
);

    // decode used by both the read and the write path
    function addr_hit;
        input [31:0] addr;
        input [31:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    reg  [31:0]  ssr_r;
    reg  [31:0]  ssr_nxt;
    reg  [15:0]  sir_up_r;
    reg  [15:0]  sir_up_nxt;
    reg  [15:0]  sir_lo_r;
    reg  [15:0]  sir_lo_nxt;
    reg  [31:0]  mask_r;
    reg  [31:0]  mask_nxt;
    reg          diag_r;
    reg  [31:0]  rdata_r;
    reg  [31:0]  rdata_nxt;
    reg          ack_r;
    reg          irq_r;
    reg  [3:0]   chan_run_r;
    reg          scsi_run_r;
    reg          enet_run_r;
    wire [3:0]   chan_run_nxt;
    wire         scsi_run_nxt;
    wire         enet_run_nxt;
    wire         irq_nxt;
    wire         hit_ssr;
    wire         hit_sir;
    wire         hit_mask;
    wire         wr_ssr;
    wire         wr_sir;
    wire         wr_mask;
    wire [15:0]  dma_set;
    wire [15:0]  dma_clr;
    wire [3:0]   page_end;
    wire [3:0]   half_page;
    wire [3:0]   chan_error;

    assign hit_ssr  = addr_hit(reg_addr_i, `SUPPORT_CTRL_ADDR);
    assign hit_sir  = addr_hit(reg_addr_i, `INTR_STATUS_ADDR);
    assign hit_mask = addr_hit(reg_addr_i, `INTR_MASK_ADDR);
    assign wr_ssr   = reg_req_i & reg_wr_i & hit_ssr;
    assign wr_sir   = reg_req_i & reg_wr_i & hit_sir;
    assign wr_mask  = reg_req_i & reg_wr_i & hit_mask;

    // support register: bit 15 and reserved bits are not stored
    always @* begin
        ssr_nxt = ssr_r;
        if (wr_ssr) begin
            ssr_nxt = reg_wdata_i & `SUP_WRITE_MASK;
        end
    end

    // write zero to clear; a condition arriving with the clear still sets
    assign dma_clr = wr_sir ? (~reg_wdata_i[31:16] & `ST_UPPER_MASK) : 16'h0000;

    always @* begin
        sir_up_nxt = ((sir_up_r & ~dma_clr) | dma_set) & `ST_UPPER_MASK;
    end

    // live device levels, one flop deep; reset value is only transient
    always @* begin
        sir_lo_nxt = 16'h0000;
        sir_lo_nxt[14] = nvr_reset_jumper_i;
        sir_lo_nxt[13:11] = slot_irq_i;
        sir_lo_nxt[10] = manufacturing_mode_jumper_i;
        sir_lo_nxt[9] = scsi_irq_i;
        sir_lo_nxt[8] = enet_irq_i;
        sir_lo_nxt[7] = serial_comm_controller_irq_i[1];
        sir_lo_nxt[6] = serial_comm_controller_irq_i[0];
        sir_lo_nxt[5] = time_of_year_clock_irq_i;
        sir_lo_nxt[4] = power_supply_warning_i;
        sir_lo_nxt[2] = scsi_data_ready_i;
        sir_lo_nxt[1] = halt_button_closed_contact_i;
        sir_lo_nxt[0] = halt_button_open_contact_i;
    end

    always @* begin
        mask_nxt = mask_r;
        if (wr_mask) begin
            mask_nxt = reg_wdata_i;
        end
    end

    // mask only gates the interrupt, never the readback
    assign irq_nxt = |({sir_up_nxt, sir_lo_nxt} & mask_nxt);

    // SCSI and Ethernet conditions come from their own engines
    assign dma_set[`ST_SCSI_PTR_BIT - 16]  = scsi_ptr_loaded_i;
    assign dma_set[`ST_SCSI_OVR_BIT - 16]  = scsi_overrun_i;
    assign dma_set[`ST_SCSI_RERR_BIT - 16] = scsi_read_err_i;
    assign dma_set[`ST_ENET_RERR_BIT - 16] = enet_read_err_i;
    assign dma_set[7:4] = 4'h0;

    // an overrun or read error halts the SCSI DMA until cleared
    assign scsi_run_nxt = ssr_nxt[`SUP_SCSI_EN_BIT]
                        & ~sir_up_nxt[`ST_SCSI_OVR_BIT - 16]
                        & ~sir_up_nxt[`ST_SCSI_RERR_BIT - 16];
    assign enet_run_nxt = ssr_nxt[`SUP_ENET_EN_BIT]
                        & ~sir_up_nxt[`ST_ENET_RERR_BIT - 16];

    // serial DMA channels, two per port
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_chan
            localparam integer BASE = (i < 2) ? `ST_P1_BASE : `ST_P2_BASE;
            localparam integer UB   = BASE - 16;

            wire err_in;

            if ((i % 2) == 0) begin : g_tx
                assign err_in = chan_err_i[i / 2];
                assign dma_set[UB]     = page_end[i];
                assign dma_set[UB - 1] = chan_error[i];
                // run stops while page end or error is pending
                assign chan_run_nxt[i] = ssr_nxt[`SUP_P1_TX_EN_BIT - i]
                                       & ~sir_up_nxt[UB]
                                       & ~sir_up_nxt[UB - 1];
            end else begin : g_rx
                assign err_in = 1'b0;
                // a full page also marks the half page
                assign dma_set[UB - 2] = half_page[i] | page_end[i];
                assign dma_set[UB - 3] = page_end[i];
                assign chan_run_nxt[i] = ssr_nxt[`SUP_P1_TX_EN_BIT - i]
                                       & ~sir_up_nxt[UB - 3];
            end

            dma_page_channel u_chan (
                .clk_sys_i   (clk_sys_i),
                .resetn_i    (resetn_i),
                .run_i       (chan_run_r[i]),
                .load_i      (chan_load_i[i]),
                .load_ptr_i  (chan_load_ptr_i[i*32 +: 32]),
                .xfer_i      (chan_xfer_i[i]),
                .err_i       (err_in),
                .ptr_o       (chan_ptr_o[i*32 +: 32]),
                .page_end_o  (page_end[i]),
                .half_page_o (half_page[i]),
                .error_o     (chan_error[i])
            );
        end
    endgenerate

    // read mux; unmapped addresses answer zero
    always @* begin
        rdata_nxt = 32'h00000000;
        if (hit_ssr) begin
            rdata_nxt = ssr_r & `SUP_WRITE_MASK;
            rdata_nxt[`SUP_DIAG_BIT] = diag_r;
        end else if (hit_sir) begin
            rdata_nxt = {sir_up_r, sir_lo_r};
        end else if (hit_mask) begin
            rdata_nxt = mask_r;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ssr_r      <= `SUP_RESET;
            sir_up_r   <= `ST_UPPER_RESET;
            sir_lo_r   <= `ST_LOWER_RESET;
            mask_r     <= `MASK_RESET;
            diag_r     <= 1'b0;
            rdata_r    <= 32'h00000000;
            ack_r      <= 1'b0;
            irq_r      <= 1'b0;
            chan_run_r <= 4'h0;
            scsi_run_r <= 1'b0;
            enet_run_r <= 1'b0;
        end else begin
            ssr_r      <= ssr_nxt;
            sir_up_r   <= sir_up_nxt;
            sir_lo_r   <= sir_lo_nxt;
            mask_r     <= mask_nxt;
            diag_r     <= manufacturing_diag_flag_i;
            rdata_r    <= (reg_req_i & ~reg_wr_i) ? rdata_nxt : 32'h00000000;
            ack_r      <= reg_req_i;
            irq_r      <= irq_nxt;
            chan_run_r <= chan_run_nxt;
            scsi_run_r <= scsi_run_nxt;
            enet_run_r <= enet_run_nxt;
        end
    end

    assign reg_rdata_o    = rdata_r;
    assign reg_ack_o      = ack_r;
    assign cpu_irq_o      = irq_r;
    assign chan_run_o     = chan_run_r;
    assign scsi_dma_run_o = scsi_run_r;
    assign enet_dma_run_o = enet_run_r;

    // pins below are plain copies of stored support bits
    assign scsi_dma_dir_o                   = ssr_r[`SUP_SCSI_DIR_BIT];
    assign serial_driver_disable_o          = ssr_r[`SUP_DRV_DIS_HI:`SUP_DRV_DIS_LO];
    assign serial_comm_controller_reset_n_o = ssr_r[`SUP_SER_RST_BIT];
    assign time_of_year_clock_reset_n_o     = ssr_r[`SUP_TOY_RST_BIT];
    assign scsi_reset_n_o                   = ssr_r[`SUP_SCSI_RST_BIT];
    assign enet_reset_n_o                   = ssr_r[`SUP_ENET_RST_BIT];
    assign led_o                            = ssr_r[`SUP_LED_HI:`SUP_LED_LO];

endmodule // io_support_regs

// ---- dv/io_support_regs_chk.sv ----
`timescale 1ns/100ps
module io_support_regs_chk (
    // clock and reset
    input wire         clk_sys_i,
    input wire         resetn_i,
    // register access
    input wire         reg_req_i,
    input wire         reg_wr_i,
    input wire [31:0]  reg_addr_i,
    input wire [31:0]  reg_wdata_i,
    input wire [31:0]  reg_rdata_o,
    input wire         reg_ack_o,
    // dma channels
    input wire [3:0]   chan_xfer_i,
    input wire [1:0]   chan_err_i,
    input wire [3:0]   chan_load_i,
    input wire [3:0]   chan_run_o,
    input wire [127:0] chan_ptr_o,
    input wire         scsi_overrun_i,
    input wire         scsi_read_err_i,
    input wire         enet_read_err_i,
    input wire         scsi_dma_run_o,
    input wire         enet_dma_run_o,
    // control pins
    input wire         scsi_dma_dir_o,
    input wire [1:0]   serial_driver_disable_o,
    input wire         serial_comm_controller_reset_n_o,
    input wire         time_of_year_clock_reset_n_o,
    input wire         scsi_reset_n_o,
    input wire         enet_reset_n_o
);
    wire sup_wr = reg_req_i && reg_wr_i && reg_addr_i == 32'hBF840100;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    a_ack_follows_req: assert property (reg_req_i |=> reg_ack_o) else $error("ack missing");
    a_idle_bus_quiet: assert property (!reg_req_i |=> !reg_ack_o && reg_rdata_o == 32'h0)
        else $error("bus not quiet");
    a_dir_follows_wr: assert property (sup_wr |=> scsi_dma_dir_o == $past(reg_wdata_i[18]))
        else $error("direction pin wrong");
    a_drv_dis_wr: assert property (sup_wr |=> serial_driver_disable_o == $past(reg_wdata_i[14:13]))
        else $error("driver disable wrong");
    a_hard_resets_wr: assert property (sup_wr |=> {serial_comm_controller_reset_n_o,
        time_of_year_clock_reset_n_o, scsi_reset_n_o, enet_reset_n_o} == $past(reg_wdata_i[11:8]))
        else $error("peripheral reset wrong");
    a_tx_en_off: assert property (sup_wr && !reg_wdata_i[31] |=> !chan_run_o[0]) else $error("tx runs");
    a_scsi_en_off: assert property (sup_wr && !reg_wdata_i[17] |=> !scsi_dma_run_o) else $error("scsi runs");
    a_enet_en_off: assert property (sup_wr && !reg_wdata_i[16] |=> !enet_dma_run_o) else $error("enet runs");
    a_tx_page_stop: assert property (chan_run_o[0] && chan_xfer_i[0] && chan_ptr_o[11:0] == 12'hFFF
        |=> !chan_run_o[0]) else $error("tx passed page end");
    a_tx_err_hold: assert property (chan_run_o[0] && chan_err_i[0] && !chan_load_i[0]
        |=> !chan_run_o[0] && chan_ptr_o[31:0] == $past(chan_ptr_o[31:0])) else $error("tx error ignored");
    a_rx_page_stop: assert property (chan_run_o[1] && chan_xfer_i[1] && chan_ptr_o[43:32] == 12'hFFF
        |=> !chan_run_o[1]) else $error("rx passed page end");
    a_scsi_err_stop: assert property (scsi_overrun_i || scsi_read_err_i
        |=> !scsi_dma_run_o) else $error("scsi dma kept running");
    a_enet_err_stop: assert property (enet_read_err_i |=> !enet_dma_run_o) else $error("enet dma kept running");
endmodule // io_support_regs_chk

bind io_support_regs io_support_regs_chk chk (.*);

// ---- dv/serial_peer.sv ----
`timescale 1ns/100ps
module serial_peer (
    // clock and reset
    input  wire       clk_sys_i,
    input  wire       resetn_i,
    // channel control
    input  wire [3:0] go_i,
    input  wire       slow_i,
    input  wire [3:0] run_i,
    // transfer pulses
    output reg  [3:0] xfer_o
);
    reg phase_r;
    // slow mode moves a unit every other cycle only
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_r <= 1'h0;
            xfer_o  <= 4'h0;
        end else begin
            phase_r <= ~phase_r;
            xfer_o  <= go_i & run_i & {4{~slow_i | phase_r}};
        end
    end
endmodule // serial_peer

// ---- dv/io_support_regs_bench.sv ----
`timescale 1ns/100ps
module io_support_regs_bench;
    reg          clk_sys_i = 0;
    reg          resetn_i  = 0;
    reg          req = 0, wr = 0, diag = 1, slow = 0;
    reg  [31:0]  addr = 0, wdata = 0, rv;
    reg  [15:0]  live = 0;
    reg  [3:0]   ld = 0, ev = 0, go = 0;
    reg  [1:0]   err = 0;
    reg  [127:0] lptr = 0;
    wire [31:0]  rdata;
    wire         ack, irq, srun, erun, dir, rs, rt, rc, re;
    wire [3:0]   run, xfer;
    wire [1:0]   dd;
    wire [7:0]   led;
    wire [127:0] ptr;
    integer      failures = 0, checks = 0, i, n;
    localparam SUP = 32'hBF840100, STA = 32'hBF840110, MSK = 32'hBF840120;
    always #5 clk_sys_i = ~clk_sys_i;
    io_support_regs DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
        .manufacturing_diag_flag_i(diag), .nvr_reset_jumper_i(live[14]), .slot_irq_i(live[13:11]),
        .manufacturing_mode_jumper_i(live[10]), .scsi_irq_i(live[9]), .enet_irq_i(live[8]),
        .serial_comm_controller_irq_i(live[7:6]), .time_of_year_clock_irq_i(live[5]),
        .power_supply_warning_i(live[4]), .scsi_data_ready_i(live[2]),
        .halt_button_closed_contact_i(live[1]), .halt_button_open_contact_i(live[0]),
        .chan_xfer_i(xfer), .chan_err_i(err), .chan_load_i(ld), .chan_load_ptr_i(lptr), .chan_run_o(run),
        .chan_ptr_o(ptr), .scsi_ptr_loaded_i(ev[3]), .scsi_overrun_i(ev[2]), .scsi_read_err_i(ev[1]),
        .enet_read_err_i(ev[0]), .scsi_dma_run_o(srun), .scsi_dma_dir_o(dir), .enet_dma_run_o(erun),
        .serial_driver_disable_o(dd), .serial_comm_controller_reset_n_o(rs),
        .time_of_year_clock_reset_n_o(rt), .scsi_reset_n_o(rc), .enet_reset_n_o(re), .led_o(led),
        .cpu_irq_o(irq));
    serial_peer peer (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .go_i(go), .slow_i(slow), .run_i(run),
        .xfer_o(xfer));
    task chk(input [31:0] got, input [31:0] exp); begin
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end endtask
    // request lasts one cycle, answer is taken 1 ns after the ack edge
    task acc(input w, input [31:0] a, input [31:0] d); begin
        req   <= 1'h1;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        req <= 1'h0;
        // look while ack and data stand, clear of the launching edge
        #1;
        rv = rdata;
        chk(ack, 1);
        @(posedge clk_sys_i);
    end endtask
    task rdc(input [31:0] a, input [31:0] exp); begin
        acc(0, a, 0);
        chk(rv, exp);
    end endtask
    task waitlow(input integer k); begin
        for (n = 0; n < 5000 && run[k]; n = n + 1)
            @(posedge clk_sys_i);
    end endtask
    task done(input integer t); begin
        $display("test %0d finished", t);
    end endtask
    task final_report; begin
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures = failures + 1;
        final_report;
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        @(posedge clk_sys_i);
        chk({rs, rt, rc, re, dd, dir}, 0);
        rdc(SUP, 32'h00008000);
        rdc(STA, 0);
        rdc(MSK, 0);
        done(1);
        acc(1, SUP, 32'hFFFFFFFF);
        chk({rs, rt, rc, re, dd, dir, led}, 15'h7FFF);
        chk({run, srun, erun}, 6'h3F);
        rdc(SUP, 32'hF007EFFF);
        diag <= 1'h0;
        acc(1, SUP, 32'h00000F00);
        rdc(SUP, 32'h00000F00);
        chk({run, srun, erun}, 0);
        done(2);
        acc(1, MSK, 32'hFFFFFFFF);
        for (i = 0; i < 15; i = i + 1) if (i != 3) begin
            live <= 16'h1 << i;
            @(posedge clk_sys_i);
            rdc(STA, 32'h1 << i);
            chk(irq, 1);
        end
        acc(1, STA, 0);
        rdc(STA, 32'h4000);
        acc(1, MSK, 0);
        chk(irq, 0);
        live <= 16'h0;
        done(3);
        lptr[31:0] <= 32'h00000FFD;
        ld <= 4'h1;
        @(posedge clk_sys_i);
        ld <= 4'h0;
        acc(1, SUP, 32'h80000F00);
        go <= 4'h1;
        waitlow(0);
        chk(ptr[31:0], 32'h1000);
        rdc(STA, 32'h80000000);
        go <= 4'h0;
        acc(1, STA, 32'hFFFFFFFF);
        chk(run[0], 0);
        acc(1, STA, 32'h7FFFFFFF);
        chk(run[0], 1);
        err <= 2'h1;
        @(posedge clk_sys_i);
        err <= 2'h0;
        @(posedge clk_sys_i);
        chk(run[0], 0);
        chk(ptr[31:0], 32'h00001000);
        rdc(STA, 32'h40000000);
        acc(1, STA, 32'hBFFFFFFF);
        chk(run[0], 1);
        acc(1, SUP, 32'h00000F00);
        done(4);
        lptr[63:32] <= 32'h000007FD;
        ld <= 4'h2;
        @(posedge clk_sys_i);
        ld <= 4'h0;
        acc(1, SUP, 32'h40000F00);
        slow <= 1'h1;
        go   <= 4'h2;
        waitlow(1);
        chk(ptr[63:32], 32'h1000);
        rdc(STA, 32'h30000000);
        go <= 4'h0;
        acc(1, STA, 0);
        rdc(STA, 0);
        done(5);
        acc(1, SUP, 32'h00030F00);
        chk({srun, erun, dir}, 3'h6);
        ev <= 4'hF;
        @(posedge clk_sys_i);
        ev <= 4'h0;
        @(posedge clk_sys_i);
        chk({srun, erun}, 0);
        rdc(STA, 32'h000F0000);
        acc(1, MSK, 32'h00010000);
        chk(irq, 1);
        acc(1, STA, 32'hFFFEFFFF);
        chk(irq, 0);
        rdc(STA, 32'h000E0000);
        rdc(32'hBF840130, 0);
        done(6);
        acc(1, SUP, 32'h20000F00);
        chk(run[2], 1);
        err <= 2'h2;
        @(posedge clk_sys_i);
        err <= 2'h0;
        @(posedge clk_sys_i);
        chk(run[2], 0);
        rdc(STA, 32'h040E0000);
        done(7);
        final_report;
    end
endmodule // io_support_regs_bench
